// *** hdl/arseq_top.sv ***
// Purpose: auto-reclose shot sequencer driven by protection trips
// Assumes: trip and breaker inputs synchronous to sys_clk
// Notes: settings are millisecond counts, zero skips the timer
`timescale 1ns/1ps
`default_nettype none
`include "arseq_map.svh"
module arseq_top #(
    parameter int NREQ = `ARSEQ_NREQ,
    parameter int TW = `ARSEQ_TW,
    parameter int TICK_CYC = `ARSEQ_TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // protection trip requests, index 0 highest priority
    input wire logic [NREQ-1:0] reclose_request,
    input wire logic critical_request,
    // per request shot enables, per shot dead and reclaim times (ms) shared by all requests
    input wire logic [NREQ-1:0] shot1_enable,
    input wire logic [NREQ-1:0] shot2_enable,
    input wire logic [TW-1:0] shot1_dead_ms,
    input wire logic [TW-1:0] shot2_dead_ms,
    input wire logic [TW-1:0] shot1_reclaim_ms,
    input wire logic [TW-1:0] shot2_reclaim_ms,
    // overall reclaim settings
    input wire logic [TW-1:0] overall_reclaim_ms,
    input wire logic overall_reclaim_use,
    input wire logic overall_fault_lockout,
    // operator reset
    input wire logic manual_reset,
    // breaker object status
    input wire arseq_pkg::arseq_obj_t obj,
    // breaker close command and sequencer status
    output logic close_request,
    output arseq_pkg::arseq_status_t status
);
    ////////////////////////////////////////////////////////////////////
    // timebase
    logic tick;

    // RQ19: shared millisecond tick
    arseq_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // helpers
    // lowest index asserted request wins
    function automatic logic [2:0] pick_req(input logic [NREQ-1:0] r);
        logic [2:0] p;
        p = 3'h0;
        for (int i = NREQ - 1; i >= 0; i--) begin
            if (r[i]) begin
                p = 3'(i);
            end
        end
        return p;
    endfunction

    // timer reached its setting; zero setting counts as done at once
    function automatic logic timer_done(input logic [TW-1:0] cnt,
                                        input logic [TW-1:0] set);
        return (cnt >= set);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state
    arseq_pkg::arseq_state_t state_reg, state_next;
    logic [2:0] req_reg, req_next; // active request index
    logic shot_reg, shot_next; // 0 first shot, 1 second
    logic [TW-1:0] tmr_reg, tmr_next; // millisecond counter
    logic close_reg, close_next;
    logic ftrip_reg, ftrip_next; // final trip pulse
    logic [TW-1:0] dead_set; // dead time of current shot
    logic [TW-1:0] rcl_set; // reclaim time of current shot
    logic any_req;
    logic same_req; // running request reasserted
    logic shot2_ok; // second shot enabled for request

    // settings of the active shot
    always_comb begin
        // RQ7: each shot keeps its own dead time
        dead_set = shot_reg ? shot2_dead_ms : shot1_dead_ms;
        rcl_set = shot_reg ? shot2_reclaim_ms : shot1_reclaim_ms;
        any_req = |reclose_request;
        same_req = reclose_request[req_reg];
        shot2_ok = shot2_enable[req_reg];
    end

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        shot_next = shot_reg;
        tmr_next = tmr_reg;
        close_next = close_reg;
        ftrip_next = 1'b0;
        // timers advance only on the tick
        if (tick && tmr_reg != {TW{1'b1}}) begin
            tmr_next = tmr_reg + {{(TW-1){1'b0}}, 1'b1};
        end
        case (state_reg)
            arseq_pkg::ST_READY: begin
                tmr_next = '0;
                // RQ16: priority pick among requests
                if (any_req) begin
                    req_next = pick_req(reclose_request);
                    // RQ15: shot one must be enabled
                    if (shot1_enable[pick_req(reclose_request)]) begin
                        // RQ1: trip starts at once, no delay
                        // RQ2: active, pending, shot one together
                        state_next = arseq_pkg::ST_WAIT_OPEN;
                        shot_next = 1'b0;
                    end else begin
                        // no shot for this request: trip final
                        ftrip_next = 1'b1;
                        state_next = arseq_pkg::ST_LOCKOUT;
                    end
                end
            end
            arseq_pkg::ST_WAIT_OPEN: begin
                tmr_next = '0;
                // RQ3: open breaker and trip gone
                if (obj.is_open && !same_req) begin
                    state_next = arseq_pkg::ST_DEAD;
                end
            end
            arseq_pkg::ST_DEAD: begin
                // RQ12: zero setting passes at once
                if (timer_done(tmr_reg, dead_set)) begin
                    // RQ4: dead time over, ask to close
                    close_next = 1'b1;
                    state_next = arseq_pkg::ST_CLOSING;
                end
            end
            arseq_pkg::ST_CLOSING: begin
                tmr_next = '0;
                // RQ17: hold request while object waits
                if (obj.is_closed) begin
                    // RQ5: drop close, start reclaim
                    close_next = 1'b0;
                    state_next = arseq_pkg::ST_RECLAIM;
                end
            end
            arseq_pkg::ST_RECLAIM: begin
                if (same_req) begin
                    tmr_next = '0;
                    if (!shot_reg && shot2_ok) begin
                        // RQ6: advance to the next shot
                        shot_next = 1'b1;
                        state_next = arseq_pkg::ST_WAIT_OPEN;
                    end else begin
                        // RQ8: no shot left, final trip
                        ftrip_next = 1'b1;
                        state_next = arseq_pkg::ST_LOCKOUT;
                    end
                end else if (timer_done(tmr_reg, rcl_set)) begin
                    // RQ10: success, clear and start overall
                    tmr_next = '0;
                    // RQ14: overall reclaim may be skipped
                    if (overall_reclaim_use) begin
                        state_next = arseq_pkg::ST_OVERALL;
                    end else begin
                        state_next = arseq_pkg::ST_READY;
                    end
                end
            end
            arseq_pkg::ST_OVERALL: begin
                if (any_req && overall_fault_lockout) begin
                    // RQ11: recurring fault goes to lockout
                    ftrip_next = 1'b1;
                    state_next = arseq_pkg::ST_LOCKOUT;
                end else if (timer_done(tmr_reg, overall_reclaim_ms)) begin
                    // RQ13: back to ready
                    state_next = arseq_pkg::ST_READY;
                end
            end
            arseq_pkg::ST_LOCKOUT: begin
                close_next = 1'b0;
                tmr_next = '0;
                // RQ9: needs reset with breaker closed
                if (manual_reset && obj.is_closed) begin
                    state_next = arseq_pkg::ST_READY;
                end
            end
            default: begin
                state_next = arseq_pkg::ST_LOCKOUT;
            end
        endcase
        // RQ16: critical request halts anywhere
        // RQ18: object failure forces lockout
        if ((critical_request || obj.fail)
            && state_reg != arseq_pkg::ST_LOCKOUT) begin
            close_next = 1'b0;
            ftrip_next = critical_request;
            state_next = arseq_pkg::ST_LOCKOUT;
        end
    end

    // sequencer registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= arseq_pkg::ST_READY;
            req_reg <= 3'h0;
            shot_reg <= 1'b0;
            tmr_reg <= '0;
            close_reg <= 1'b0;
            ftrip_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            shot_reg <= shot_next;
            tmr_reg <= tmr_next;
            close_reg <= close_next;
            ftrip_reg <= ftrip_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, decoded from registered state
    logic running;

    always_comb begin
        running = (state_reg == arseq_pkg::ST_WAIT_OPEN)
               || (state_reg == arseq_pkg::ST_DEAD)
               || (state_reg == arseq_pkg::ST_CLOSING)
               || (state_reg == arseq_pkg::ST_RECLAIM);
        status = '0;
        status.recloser_active = running;
        status.recloser_lockout = (state_reg == arseq_pkg::ST_LOCKOUT);
        status.post_cycle_reclaim = (state_reg == arseq_pkg::ST_OVERALL);
        status.final_trip = ftrip_reg;
        if (running) begin
            status.request_pending[req_reg] = 1'b1;
            status.shot_active[shot_reg] = 1'b1;
        end
    end

    assign close_request = close_reg;
endmodule
`default_nettype wire

// *** hdl/arseq_map.svh ***
// Purpose: constants for the auto-reclose shot sequencer
// Assumes: 10 MHz sys_clk, 1 ms timebase tick
// Notes: times are in ms, settings are ms counts
// Summary of operation
// RQ1: trip initiator, no extra start delay
// RQ2: trip sets active, pending, shot one
// RQ3: breaker open, trip gone: dead time
// RQ4: dead time expiry raises close request
// RQ5: closed indication drops close, starts reclaim
// RQ6: reassert in reclaim advances shot
// RQ7: each shot has own dead time
// RQ8: no shot left: final trip, lockout
// RQ9: lockout held until reset and closed
// RQ10: reclaim expiry clears flags, overall reclaim
// RQ11: fault in overall reclaim may lockout
// RQ12: zero setting bypasses that timer
// RQ13: overall reclaim expiry returns ready
// RQ14: overall reclaim may be skipped
// RQ15: two separately enabled shots per request
// RQ16: five ranked requests plus critical
// RQ17: wait for object close acknowledge
// RQ18: object failure forces lockout
// RQ19: timers count common millisecond tick
`ifndef ARSEQ_MAP_SVH
`define ARSEQ_MAP_SVH
`define ARSEQ_CLK_HZ 10000000
`define ARSEQ_TICK_US 1000
`define ARSEQ_TICK_CYC ((`ARSEQ_CLK_HZ / 1000000) * `ARSEQ_TICK_US)
`define ARSEQ_NREQ 5
`define ARSEQ_NSHOT 2
`define ARSEQ_TW 20
`define ARSEQ_DEAD1_MS 200
`define ARSEQ_DEAD2_MS 60000
`define ARSEQ_RECLAIM_MS 10000
`endif

// *** hdl/arseq_pkg.sv ***
// Purpose: types for the auto-reclose shot sequencer
// Assumes: arseq_map.svh holds the numbers
// Notes: nothing here is imported
package arseq_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        ST_READY, ST_WAIT_OPEN, ST_DEAD, ST_CLOSING, ST_RECLAIM,
        ST_OVERALL, ST_LOCKOUT
    } arseq_state_t;
    // status flags shown to the outside
    typedef struct packed {
        logic recloser_active;
        logic recloser_lockout;
        logic post_cycle_reclaim;
        logic final_trip;
        logic [4:0] request_pending;
        logic [1:0] shot_active;
    } arseq_status_t;
    // breaker object acknowledges
    typedef struct packed {
        logic is_open;
        logic is_closed;
        logic close_wait;
        logic fail;
    } arseq_obj_t;
endpackage

// *** hdl/arseq_tick.sv ***
// Purpose: millisecond timebase enable for the sequencer timers
// Assumes: sys_clk 10 MHz
// Notes: one-cycle pulse every TICK_CYC clocks
`timescale 1ns/1ps
`default_nettype none
`include "arseq_map.svh"
module arseq_tick #(
    parameter int TICK_CYC = `ARSEQ_TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // tick out
    output logic tick
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    // divider next state
    always_comb begin
        cnt_next = cnt_reg + 16'h0001;
        tick_next = 1'b0;
        if (cnt_reg == 16'(TICK_CYC - 1)) begin
            cnt_next = 16'h0000;
            tick_next = 1'b1;
        end
    end

    // divider registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule
`default_nettype wire

// *** testbench/arseq_chk.sv ***
// Purpose: port-level checks on the reclose sequencer
// Assumes: status is a decode of state, final_trip a pulse
// Notes: bound into every arseq_top instance
`timescale 1ns/1ps
`default_nettype none
module arseq_chk #(
    parameter int NREQ = 5
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // inputs watched
    input wire logic [NREQ-1:0] reclose_request,
    input wire logic critical_request,
    input wire logic [NREQ-1:0] shot1_enable,
    input wire logic overall_fault_lockout,
    input wire logic manual_reset,
    input wire arseq_pkg::arseq_obj_t obj,
    // outputs watched
    input wire logic close_request,
    input wire arseq_pkg::arseq_status_t status
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////
    a_start_flags: assert property (
        !status.recloser_active && !status.recloser_lockout &&
        !status.post_cycle_reclaim && !critical_request &&
        reclose_request[1:0] == 2'h2 && shot1_enable[1] |=>
        status.recloser_active && status.request_pending == 5'h02 &&
        status.shot_active == 2'h1) else $error("start flags wrong");
    a_close_drop: assert property (
        close_request && obj.is_closed |=> !close_request)
        else $error("close held after closed");
    a_lock_holds: assert property (
        status.recloser_lockout && !(manual_reset && obj.is_closed) |=>
        status.recloser_lockout) else $error("lockout left early");
    a_lock_clear: assert property (
        status.recloser_lockout |-> !status.recloser_active &&
        status.request_pending == 5'h00 && status.shot_active == 2'h0)
        else $error("flags set in lockout");
    a_final_pulse: assert property (
        status.final_trip |=> !status.final_trip && status.recloser_lockout)
        else $error("final trip not a pulse into lockout");
    a_crit_halt: assert property (
        $rose(critical_request) |-> ##[1:3] status.recloser_lockout)
        else $error("critical did not halt");
    a_fail_lock: assert property (
        status.recloser_active && obj.fail |-> ##[1:3]
        status.recloser_lockout) else $error("object failure ignored");
    a_overall_lock: assert property (
        status.post_cycle_reclaim && overall_fault_lockout &&
        reclose_request != 5'h00 |-> ##[1:3] status.recloser_lockout)
        else $error("fault in overall reclaim ignored");
endmodule
bind arseq_top arseq_chk #(.NREQ(NREQ)) u_chk (.sys_clk(sys_clk),
    .rst_b(rst_b), .reclose_request(reclose_request),
    .critical_request(critical_request), .shot1_enable(shot1_enable),
    .overall_fault_lockout(overall_fault_lockout),
    .manual_reset(manual_reset), .obj(obj),
    .close_request(close_request), .status(status));
`default_nettype wire

// *** testbench/arseq_brk.sv ***
// Purpose: breaker object model at the far side of the sequencer
// Assumes: open and operator close come from the bench
// Notes: slow mode stands for a close held back by interlocks
`timescale 1ns/1ps
`default_nettype none
module arseq_brk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // commands
    input wire logic close_request,
    input wire logic open_cmd,
    input wire logic man_close,
    input wire logic fail_cmd,
    input wire logic slow,
    // status back
    output var arseq_pkg::arseq_obj_t obj
);
    logic closed_reg; // breaker position
    logic [3:0] wait_reg; // cycles the close has waited
    wire logic [3:0] lim = slow ? 4'hA : 4'h1; // closing conditions delay
    // close coil only once conditions met
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            closed_reg <= 1'b1;
            wait_reg <= 4'h0;
        end else begin
            wait_reg <= (close_request && !closed_reg) ? wait_reg + 4'h1
                                                       : 4'h0;
            if (open_cmd) closed_reg <= 1'b0;
            else if (man_close || (close_request && wait_reg >= lim))
                closed_reg <= 1'b1;
        end
    end
    assign obj = {!closed_reg, closed_reg, close_request && !closed_reg && slow,
        fail_cmd};
endmodule
`default_nettype wire

// *** testbench/test_arseq_top.sv ***
// Purpose: scenario bench for the reclose sequencer
// Assumes: 4-clock ms tick, breaker model at the far side
// Notes: each task drives one sequence and judges it
`timescale 1ns/1ps
`default_nettype none
module test_arseq_top;
    localparam int TK = 4; // clocks per ms tick
    localparam int RC = 20; // shot reclaim ms
    logic sys_clk = 1'b0, rst_b = 1'b0, crit = 1'b0, use_ov = 1'b1;
    logic ov_lock = 1'b0, man_rst = 1'b0, open_cmd = 1'b0, slow = 1'b0;
    logic man_close = 1'b0, fail_cmd = 1'b0, close_request;
    logic [4:0] req = 5'h00, en1 = 5'h1F; // trips and shot one enables
    logic [19:0] dead1 = 20'h00003; // fast shot dead ms
    arseq_pkg::arseq_obj_t obj;
    arseq_pkg::arseq_status_t status;
    int err_count = 0, n_compared = 0, cycles = 0;
    arseq_top #(.TICK_CYC(TK)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .reclose_request(req), .critical_request(crit), .shot1_enable(en1),
        .shot2_enable(5'h0F), .shot1_dead_ms(dead1),
        .shot2_dead_ms(20'h0000A), .shot1_reclaim_ms(20'h00014),
        .shot2_reclaim_ms(20'h00014), .overall_reclaim_ms(20'h0000A),
        .overall_reclaim_use(use_ov), .overall_fault_lockout(ov_lock),
        .manual_reset(man_rst), .obj(obj), .close_request(close_request),
        .status(status));
    arseq_brk brk (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
        .close_request(close_request), .open_cmd(open_cmd),
        .man_close(man_close), .fail_cmd(fail_cmd), .obj(obj));
    always #50 sys_clk = ~sys_clk;
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [11:0] got, input logic [11:0] want);
        n_compared++;
        if (got !== want) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("ERROR %0t count %0d not in %0d..%0d", $time, got,
                lo, hi);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // raise trips, settle past the answer cycle
    task automatic trip(input logic [4:0] r);
        @(posedge sys_clk);
        req <= r;
        repeat (3) @(negedge sys_clk);
    endtask
    // open, drop trip, time dead phase, let breaker close
    task automatic shot_run(input int d, input logic s);
        int n;
        @(posedge sys_clk);
        slow <= s;
        open_cmd <= 1'b1;
        req <= 5'h00;
        @(posedge sys_clk);
        open_cmd <= 1'b0;
        n = 0;
        while (close_request !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        chk_rng(n, (d - 1) * TK, (d + 2) * TK + 8);
        repeat (6) @(negedge sys_clk);
        chk(close_request, s);
        repeat (14) @(negedge sys_clk);
        chk(close_request, 1'b0);
    endtask
    // operator reset with breaker closed
    task automatic unlock;
        @(posedge sys_clk);
        {req, crit, fail_cmd, open_cmd} <= 8'h00;
        {man_close, man_rst} <= 2'h3;
        repeat (3) @(posedge sys_clk);
        {man_close, man_rst} <= 2'h0;
        repeat (2) @(negedge sys_clk);
        chk(status, 12'h000);
    endtask
    ////////////////////////////////////////////////////////////////////
    // status is 11 bits: active 400, lockout 200, overall 100, final 080,
    // pending[i] 004 << i, shot one 001, shot two 002
    task automatic t_two_fail;
        trip(5'h02);
        chk(status, 12'h409);
        shot_run(3, 1'b0);
        trip(5'h02);
        chk(status, 12'h40A);
        shot_run(10, 1'b1);
        trip(5'h02);
        chk(status, 12'h200);
        @(posedge sys_clk);
        open_cmd <= 1'b1;
        req <= 5'h00;
        trip(5'h01);
        chk(status, 12'h200);
        @(posedge sys_clk);
        man_rst <= 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(status, 12'h200);
        unlock();
        $display("t_two_fail done");
    endtask
    task automatic t_success(input logic u, input logic fl, input int d);
        @(posedge sys_clk);
        {use_ov, ov_lock} <= {u, fl};
        dead1 <= 20'(d);
        trip(5'h04);
        chk(status, 12'h411);
        shot_run(d, 1'b0);
        repeat (RC * TK) @(negedge sys_clk);
        chk(status, u ? 12'h100 : 12'h000);
        if (fl) begin
            trip(5'h04);
            chk(status, 12'h200);
            unlock();
        end else begin
            repeat (48) @(negedge sys_clk);
            chk(status, 12'h000);
        end
        $display("t_success done");
    endtask
    task automatic t_crit_fail;
        trip(5'h06);
        chk(status, 12'h409);
        @(posedge sys_clk);
        crit <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(status, 12'h200);
        unlock();
        trip(5'h01);
        chk(status, 12'h405);
        @(posedge sys_clk);
        fail_cmd <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(status, 12'h200);
        unlock();
        $display("t_crit_fail done");
    endtask
    task automatic t_no_shot2;
        trip(5'h10);
        chk(status, 12'h441);
        shot_run(3, 1'b0);
        trip(5'h10);
        chk(status, 12'h200);
        unlock();
        @(posedge sys_clk);
        en1 <= 5'h0F;
        trip(5'h10);
        chk(status, 12'h200);
        unlock();
        $display("t_no_shot2 done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_two_fail();
        t_success(1'b1, 1'b0, 3);
        t_success(1'b0, 1'b0, 0);
        t_success(1'b1, 1'b1, 3);
        t_crit_fail();
        t_no_shot2();
        wrap_up();
    end
endmodule
`default_nettype wire
